// ### uep_pkg.sv
// Constants and types for the endpoint transaction engine
package uep_pkg;
    // Register byte offsets
    localparam logic [7:0] A_MODE = 8'h00;
    localparam logic [7:0] A_CMD = 8'h04;
    localparam logic [7:0] A_SETUP_STAT = 8'h08;
    localparam logic [7:0] A_PRIME = 8'h0C;
    localparam logic [7:0] A_STATUS = 8'h10;
    localparam logic [7:0] A_EPCTRL = 8'h14;
    localparam logic [7:0] A_RX_QH = 8'h18;
    localparam logic [7:0] A_TX_QH = 8'h1C;
    localparam logic [7:0] A_RX_TD = 8'h20;
    localparam logic [7:0] A_TX_TD = 8'h24;
    localparam logic [7:0] A_RX_NX = 8'h28;
    localparam logic [7:0] A_TX_NX = 8'h2C;
    localparam logic [7:0] A_SETUP0 = 8'h30;
    localparam logic [7:0] A_SETUP1 = 8'h34;
    localparam logic [7:0] A_ERR = 8'h38;
    // Field positions
    localparam int EP_TYPE_LSB = 2;
    localparam int QH_ZLTERM_BIT = 15;
    localparam int QH_MUL_LSB = 16;
    localparam int TD_TERM_BIT = 16;
    localparam int TD_BERR_BIT = 30;
    localparam int TD_ACT_BIT = 31;
    // Widths
    localparam int BW = 15;
    localparam int LW = 11;
    // Reset values
    localparam logic [LW-1:0] MPL_RST = 11'h000;
    localparam logic [1:0] EP_TYPE_RST = 2'h0;
    // Descriptor fetch time during a prime
    localparam int CLK_PERIOD_NS = 25;
    localparam int PRIME_FETCH_NS = 100;
    localparam int PRIME_CYC = (PRIME_FETCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] PRIME_LAST = 3'(PRIME_CYC - 1);
    // Endpoint types
    typedef enum logic [1:0] {
        EP_CTRL = 2'b00,
        EP_ISO = 2'b01,
        EP_BULK = 2'b10,
        EP_INTR = 2'b11
    } uep_eptype_t;
    // Tokens from the link
    typedef enum logic [2:0] {
        TOK_SETUP = 3'b000,
        TOK_IN = 3'b001,
        TOK_OUT = 3'b010,
        TOK_PING = 3'b011,
        TOK_BAD = 3'b111
    } uep_tok_t;
    // Answers to the link
    typedef enum logic [2:0] {
        RSP_NONE = 3'b000,
        RSP_ACK = 3'b001,
        RSP_NAK = 3'b010,
        RSP_STALL = 3'b011,
        RSP_NYET = 3'b100,
        RSP_DATA = 3'b101,
        RSP_BSERR = 3'b110
    } uep_rsp_t;
    // Transmit handshake wait
    typedef enum logic {
        TXS_IDLE = 1'b0,
        TXS_WAIT = 1'b1
    } uep_txs_t;
endpackage

// ### uep_setup_mem.sv
// Eight-byte setup packet store with registered read port
`timescale 1ns/100ps
module uep_setup_mem (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Write side
    input wire logic we,
    input wire logic [63:0] wdata,
    // Read side
    input wire logic raddr,
    output logic [31:0] rdata
);
    logic [1:0][31:0] mem;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem <= 64'h0;
            rdata <= 32'h0;
        end else begin
            if (we) begin
                mem <= wdata;
            end
            rdata <= mem[raddr];
        end
    end
endmodule

// ### uep_engine.sv
// Bulk, interrupt and control endpoint transaction engine with APB registers
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/100ps
//
// Contract
// R01: Unprimed endpoint answers IN and OUT with NAK
// R02: Without termination flag, exact multiple ends with empty packet
// R03: With termination flag, rounded-up count, no empty tail
// R04: Software keeps packet multiplier at zero
// R05: Transmit descriptor completes with zero bytes left
// R06: Receive completes on all packets or short packet
// R07: Long packet: buffer error, flush, bus error
// R08: On completion clear active, chain or flush
// R09: Failed descriptor stays current until software repairs
// R10: Packet faults retried without software action
// R11: Bulk IN matrix; setup and invalid ignored
// R12: OUT and PING matrix by stall and prime
// R13: Accepted OUT gets ACK if packets remain, else NYET
// R14: Control setup always acknowledged unless lockout engaged
// R15: Software sets lockout mode bit at initialization
// R16: Software copies setup under tripwire semaphore
// R17: Setup received bit cleared by writing one
// R18: Prime ends: primed bit set on success only
// R19: New setup clears primed status of control endpoint
// R20: Software rechecks setup status after priming
// R21: Software primes zero-length status descriptor
// R22: Control IN matrix with underflow bit-stuff error
// R23: Stored new setup clears the tripwire bit
// R24: Completed prime shows endpoint primed
module uep_engine (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Tokens from the link
    input wire logic tok_valid,
    input wire uep_pkg::uep_tok_t tok_pid,
    input wire logic [10:0] tok_len,
    input wire logic tok_crc_ok,
    input wire logic tok_overflow,
    input wire logic tok_underflow,
    input wire logic tx_done,
    input wire logic tx_acked,
    input wire logic [63:0] setup_data,
    // Answers to the link
    output logic resp_valid,
    output uep_pkg::uep_rsp_t resp_code,
    output logic [10:0] resp_len,
    // Error level
    output logic bus_err_irq
);
    import uep_pkg::*;

    typedef struct packed {
        logic lockout_mode;
        logic tripwire;
        logic setup_stat;
        logic [1:0] prime;
        logic [1:0] primed;
        logic [1:0] pfail;
        logic [2:0] pcnt;
        logic [1:0] stall;
        logic [1:0] eptype;
        logic [1:0][LW-1:0] mpl;
        logic [1:0] zl_term;
        logic [1:0][1:0] pkt_mul;
        logic [1:0][BW-1:0] td_bytes;
        logic [1:0] td_term;
        logic [1:0] td_act;
        logic [1:0] td_berr;
        logic [1:0][BW-1:0] nx_bytes;
        logic [1:0] nx_term;
        logic [1:0] nx_act;
        uep_txs_t txs;
        logic bus_err;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic resp_valid;
        uep_rsp_t resp_code;
        logic [LW-1:0] resp_len;
    } uep_st_t;

    uep_st_t st_r;
    uep_st_t st_nxt;
    logic acc;
    logic wr;
    logic ctrl_ep;
    logic setup_ok;
    logic [1:0] ret;
    logic [LW-1:0] psz;
    logic [BW-1:0] rem;
    logic [31:0] rd_mux;
    logic [31:0] mem_rdata;

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a[1:0] == 2'h0) && (a <= A_ERR);
    endfunction

    // Next packet length: full size or the shorter remainder
    function automatic logic [LW-1:0] pkt_size(input logic [BW-1:0] r,
                                               input logic [LW-1:0] m);
        pkt_size = (r < BW'(m)) ? LW'(r) : m;
    endfunction

    assign acc = psel && penable && !st_r.pready;
    assign wr = psel && penable && st_r.pready && pwrite;
    assign ctrl_ep = (st_r.eptype == EP_CTRL);
    // Lockout engages only while a stored setup is still unread
    assign setup_ok = tok_valid && (tok_pid == TOK_SETUP) && ctrl_ep
                      && (st_r.lockout_mode || !st_r.setup_stat);

    uep_setup_mem u_setup_mem (
        .pclk(pclk),
        .presetn(presetn),
        .we(setup_ok),
        .wdata(setup_data),
        .raddr(paddr[2]),
        .rdata(mem_rdata)
    );

    always_comb begin
        unique case (paddr)
            A_MODE: rd_mux = {31'h0, st_r.lockout_mode};
            A_CMD: rd_mux = {31'h0, st_r.tripwire};
            A_SETUP_STAT: rd_mux = {31'h0, st_r.setup_stat};
            A_PRIME: rd_mux = {30'h0, st_r.prime};
            A_STATUS: rd_mux = {30'h0, st_r.primed};
            A_EPCTRL: rd_mux = {28'h0, st_r.eptype, st_r.stall};
            A_RX_QH, A_TX_QH: rd_mux = {14'h0, st_r.pkt_mul[paddr[2]],
                st_r.zl_term[paddr[2]], 4'h0, st_r.mpl[paddr[2]]};
            A_RX_TD, A_TX_TD: rd_mux = {st_r.td_act[paddr[2]], st_r.td_berr[paddr[2]],
                13'h0, st_r.td_term[paddr[2]], 1'b0, st_r.td_bytes[paddr[2]]};
            A_RX_NX, A_TX_NX: rd_mux = {st_r.nx_act[paddr[2]], 14'h0,
                st_r.nx_term[paddr[2]], 1'b0, st_r.nx_bytes[paddr[2]]};
            A_SETUP0, A_SETUP1: rd_mux = mem_rdata;
            A_ERR: rd_mux = {31'h0, st_r.bus_err};
            default: rd_mux = 32'h0;
        endcase
    end

    always_comb begin
        st_nxt = st_r;
        ret = 2'b00;
        psz = '0;
        rem = '0;
        st_nxt.resp_valid = 1'b0;
        st_nxt.resp_code = RSP_NONE;
        // Two-cycle access phase: read data captured on the same edge that raises pready
        st_nxt.pready = acc;
        if (acc) begin
            st_nxt.prdata = rd_mux;
            st_nxt.pslverr = !addr_ok(paddr);
        end
        // Software writes come first so hardware events override them
        if (wr) begin
            unique case (paddr)
                A_MODE: st_nxt.lockout_mode = pwdata[0];
                A_CMD: st_nxt.tripwire = pwdata[0];
                A_SETUP_STAT: begin
                    if (pwdata[0]) begin
                        st_nxt.setup_stat = 1'b0; // R17
                    end
                end
                A_PRIME: st_nxt.prime = st_r.prime | pwdata[1:0];
                A_EPCTRL: begin
                    st_nxt.stall = pwdata[1:0];
                    st_nxt.eptype = pwdata[EP_TYPE_LSB+:2];
                end
                A_RX_QH, A_TX_QH: begin
                    st_nxt.mpl[paddr[2]] = pwdata[LW-1:0];
                    st_nxt.zl_term[paddr[2]] = pwdata[QH_ZLTERM_BIT];
                    st_nxt.pkt_mul[paddr[2]] = pwdata[QH_MUL_LSB+:2];
                end
                A_RX_TD, A_TX_TD: begin
                    st_nxt.td_bytes[paddr[2]] = pwdata[BW-1:0];
                    st_nxt.td_term[paddr[2]] = pwdata[TD_TERM_BIT];
                    st_nxt.td_berr[paddr[2]] = pwdata[TD_BERR_BIT];
                    st_nxt.td_act[paddr[2]] = pwdata[TD_ACT_BIT];
                end
                A_RX_NX, A_TX_NX: begin
                    st_nxt.nx_bytes[paddr[2]] = pwdata[BW-1:0];
                    st_nxt.nx_term[paddr[2]] = pwdata[TD_TERM_BIT];
                    st_nxt.nx_act[paddr[2]] = pwdata[TD_ACT_BIT];
                end
                A_ERR: begin
                    if (pwdata[0]) begin
                        st_nxt.bus_err = 1'b0;
                    end
                end
                default: st_nxt.pslverr = st_r.pslverr;
            endcase
        end
        // Descriptor fetch; an unusable descriptor fails the prime
        if (|st_r.prime) begin
            st_nxt.pcnt = st_r.pcnt + 3'h1;
            if (st_r.pcnt == PRIME_LAST) begin
                st_nxt.pcnt = 3'h0;
                st_nxt.pfail = 2'b00;
                for (int d = 0; d < 2; d++) begin
                    if (st_r.prime[d]) begin
                        st_nxt.prime[d] = 1'b0; // R18
                        if (st_r.td_act[d] && !st_r.td_berr[d] && (st_r.mpl[d] != '0)
                            && !st_r.pfail[d]) begin
                            st_nxt.primed[d] = 1'b1; // R24
                        end
                    end
                end
            end
        end
        if (tok_valid) begin
            case (tok_pid)
                TOK_SETUP: begin
                    if (setup_ok) begin
                        st_nxt.resp_valid = 1'b1;
                        st_nxt.resp_code = RSP_ACK; // R14
                        st_nxt.setup_stat = 1'b1;
                        st_nxt.tripwire = 1'b0; // R23
                        st_nxt.primed = 2'b00; // R19
                        st_nxt.pfail = st_nxt.prime;
                        st_nxt.stall = 2'b00;
                    end
                end
                TOK_IN: begin
                    st_nxt.resp_valid = 1'b1;
                    if (st_r.stall[1]) begin
                        st_nxt.resp_code = RSP_STALL; // R11 R22
                    end else if (!st_r.primed[1]) begin
                        st_nxt.resp_code = RSP_NAK; // R01
                    end else if (tok_underflow) begin
                        st_nxt.resp_code = RSP_BSERR; // R11 R22
                    end else begin
                        st_nxt.resp_code = RSP_DATA;
                        st_nxt.resp_len = pkt_size(st_r.td_bytes[1], st_r.mpl[1]);
                        st_nxt.txs = TXS_WAIT;
                    end
                end
                TOK_OUT: begin
                    st_nxt.resp_valid = 1'b1;
                    rem = st_r.td_bytes[0] - BW'(tok_len);
                    if (st_r.stall[0]) begin
                        st_nxt.resp_code = RSP_STALL; // R12
                    end else if (!st_r.primed[0] || tok_overflow) begin
                        st_nxt.resp_code = RSP_NAK; // R01 R12
                    end else if (!tok_crc_ok) begin
                        // Silence makes the host resend
                        st_nxt.resp_valid = 1'b0; // R10
                    end else if ((tok_len > st_r.mpl[0])
                                 || (BW'(tok_len) > st_r.td_bytes[0])) begin
                        // Descriptor stays current for software repair
                        st_nxt.resp_valid = 1'b0; // R07 R09
                        st_nxt.td_berr[0] = 1'b1;
                        st_nxt.primed[0] = 1'b0;
                        st_nxt.bus_err = 1'b1;
                    end else begin
                        st_nxt.td_bytes[0] = rem;
                        if ((tok_len < st_r.mpl[0])
                            || (st_r.zl_term[0] && (rem == '0))) begin // R06
                            st_nxt.resp_code = RSP_NYET; // R13
                            ret[0] = 1'b1;
                        end else begin
                            st_nxt.resp_code = RSP_ACK; // R13
                        end
                    end
                end
                TOK_PING: begin
                    st_nxt.resp_valid = 1'b1;
                    if (st_r.stall[0]) begin
                        st_nxt.resp_code = RSP_STALL; // R12
                    end else if (!st_r.primed[0]) begin
                        st_nxt.resp_code = RSP_NAK; // R12
                    end else begin
                        st_nxt.resp_code = RSP_ACK; // R12
                    end
                end
                default: st_nxt.resp_valid = 1'b0; // R11 R22
            endcase
        end
        // Unacknowledged transmit leaves the descriptor for a retry
        if (tx_done && (st_r.txs == TXS_WAIT)) begin
            st_nxt.txs = TXS_IDLE;
            if (tx_acked && st_r.primed[1]) begin // R10
                psz = pkt_size(st_r.td_bytes[1], st_r.mpl[1]);
                st_nxt.td_bytes[1] = st_r.td_bytes[1] - BW'(psz); // R05
                if (st_r.zl_term[1] ? (st_nxt.td_bytes[1] == '0) // R03
                                    : (psz < st_r.mpl[1])) begin // R02
                    ret[1] = 1'b1;
                end
            end
        end
        for (int d = 0; d < 2; d++) begin
            if (ret[d]) begin
                st_nxt.td_act[d] = 1'b0; // R08
                if (!st_r.td_term[d] && st_r.nx_act[d]) begin
                    st_nxt.td_bytes[d] = st_r.nx_bytes[d];
                    st_nxt.td_term[d] = st_r.nx_term[d];
                    st_nxt.td_act[d] = 1'b1;
                    st_nxt.nx_act[d] = 1'b0;
                end else begin
                    st_nxt.primed[d] = 1'b0; // R08
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
            st_r.mpl <= {MPL_RST, MPL_RST};
            st_r.eptype <= EP_TYPE_RST;
            st_r.td_term <= 2'b11;
            st_r.nx_term <= 2'b11;
            st_r.txs <= TXS_IDLE;
            st_r.resp_code <= RSP_NONE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;
    assign resp_valid = st_r.resp_valid;
    assign resp_code = st_r.resp_code;
    assign resp_len = st_r.resp_len;
    assign bus_err_irq = st_r.bus_err;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_nak_unprimed;
        tok_valid && (tok_pid == TOK_IN) && !st_r.stall[1] && !st_r.primed[1]
            |=> resp_valid && (resp_code == RSP_NAK);
    endproperty
    a_nak_unprimed: assert property (p_nak_unprimed) else $error("IN not NAKed"); // R01

    property p_zlp_tail;
        tx_done && tx_acked && (st_r.txs == TXS_WAIT) && st_r.primed[1] && !st_r.zl_term[1]
            && (st_r.td_bytes[1] == '0) && !st_r.nx_act[1] |=> !st_r.primed[1];
    endproperty
    a_zlp_tail: assert property (p_zlp_tail) else $error("Empty packet did not end"); // R02

    property p_zlt_end;
        tx_done && tx_acked && (st_r.txs == TXS_WAIT) && st_r.primed[1] && st_r.zl_term[1]
            && (st_r.mpl[1] != '0) && (st_r.td_bytes[1] == BW'(st_r.mpl[1]))
            && !st_r.nx_act[1] |=> !st_r.primed[1] ##1 !st_r.primed[1];
    endproperty
    a_zlt_end: assert property (p_zlt_end) else $error("Full last packet not final"); // R03

    property p_tx_zero;
        $fell(st_r.td_act[1]) && $past(tx_done) |-> (st_r.td_bytes[1] == '0);
    endproperty
    a_tx_zero: assert property (p_tx_zero) else $error("Bytes left at completion"); // R05

    property p_long_pkt;
        tok_valid && (tok_pid == TOK_OUT) && st_r.primed[0] && !st_r.stall[0]
            && !tok_overflow && tok_crc_ok && (tok_len > st_r.mpl[0])
            |=> st_r.td_berr[0] && !st_r.primed[0] && bus_err_irq && !resp_valid;
    endproperty
    a_long_pkt: assert property (p_long_pkt) else $error("Long packet not flagged"); // R07

    property p_crc_retry;
        tok_valid && (tok_pid == TOK_OUT) && st_r.primed[0] && !st_r.stall[0]
            && !tok_overflow && !tok_crc_ok |=> !resp_valid && $stable(st_r.td_bytes[0]);
    endproperty
    a_crc_retry: assert property (p_crc_retry) else $error("CRC fault not retried"); // R10

    property p_out_ack;
        tok_valid && (tok_pid == TOK_OUT) && st_r.primed[0] && !st_r.stall[0]
            && !tok_overflow && tok_crc_ok && (tok_len == st_r.mpl[0])
            && (BW'(tok_len) < st_r.td_bytes[0]) |=> (resp_code == RSP_ACK);
    endproperty
    a_out_ack: assert property (p_out_ack) else $error("OUT with room not ACKed"); // R13

    property p_setup_take;
        setup_ok |=> resp_valid && (resp_code == RSP_ACK) && st_r.setup_stat
            && !st_r.tripwire;
    endproperty
    a_setup_take: assert property (p_setup_take) else $error("Setup not taken"); // R14

    property p_setup_flush;
        setup_ok |=> (st_r.primed == 2'b00);
    endproperty
    a_setup_flush: assert property (p_setup_flush) else $error("Setup kept primed"); // R19

    property p_prime_fail;
        $fell(st_r.prime[0]) && !$past(st_r.primed[0]) && ($past(st_r.mpl[0]) == '0)
            |-> !st_r.primed[0];
    endproperty
    a_prime_fail: assert property (p_prime_fail) else $error("Bad prime succeeded"); // R18

    property p_stall_in;
        tok_valid && (tok_pid == TOK_IN) && st_r.stall[1] |=> (resp_code == RSP_STALL);
    endproperty
    a_stall_in: assert property (p_stall_in) else $error("Stalled IN answered"); // R11

    c_setup: cover property (setup_ok ##1 resp_valid);
    c_tx_done: cover property ($fell(st_r.td_act[1]));
    c_rx_short: cover property ($fell(st_r.td_act[0]) && (st_r.td_bytes[0] != '0));
    c_prime_ok: cover property ($rose(st_r.primed[0]));
endmodule

// ### uep_host.sv
// Host-side token source standing in for the bus host
`timescale 1ns/100ps
module uep_host (
    // Clock
    input wire logic pclk,
    // Tokens to the engine
    output logic tok_valid,
    output uep_pkg::uep_tok_t tok_pid,
    output logic [10:0] tok_len,
    output logic tok_crc_ok,
    output logic tok_overflow,
    output logic tok_underflow,
    output logic [63:0] setup_data,
    // Transmit handshake
    output logic tx_done,
    output logic tx_acked
);
    import uep_pkg::*;
    initial begin
        tok_valid = 1'h0;
        tok_pid = TOK_BAD;
        tok_len = 11'h000;
        {tok_crc_ok, tok_overflow, tok_underflow} = 3'h0;
        setup_data = 64'h0;
        tx_done = 1'h0;
        tx_acked = 1'h0;
    end
    // One token; lines are scrambled after so stale values never look valid
    task automatic tok(input uep_tok_t p, input logic [10:0] n, input logic [2:0] f,
        input logic [63:0] sd);
        @(posedge pclk);
        tok_valid <= 1'h1;
        tok_pid <= p;
        tok_len <= n;
        {tok_crc_ok, tok_overflow, tok_underflow} <= f;
        setup_data <= sd;
        @(posedge pclk);
        tok_valid <= 1'h0;
        tok_len <= ~n;
        {tok_crc_ok, tok_overflow, tok_underflow} <= ~f;
        setup_data <= ~sd;
    endtask
    // Handshake phase; an unacked one makes the engine resend
    task automatic txd(input logic a);
        @(posedge pclk);
        tx_done <= 1'h1;
        tx_acked <= a;
        @(posedge pclk);
        tx_done <= 1'h0;
        tx_acked <= ~a;
    endtask
endmodule

// ### uep_engine_tb.sv
// Self-checking bench for the endpoint engine
`timescale 1ns/100ps
module uep_engine_tb;
    import uep_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, resp_valid, bus_err_irq;
    logic tok_valid, tok_crc_ok, tok_overflow, tok_underflow, tx_done, tx_acked, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [10:0] tok_len, resp_len;
    logic [63:0] setup_data, sdat;
    uep_tok_t tok_pid;
    uep_rsp_t resp_code;
    int bad_count = 0;
    int checked = 0;
    uep_engine dut_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .tok_valid, .tok_pid, .tok_len, .tok_crc_ok, .tok_overflow,
        .tok_underflow, .tx_done, .tx_acked, .setup_data, .resp_valid, .resp_code,
        .resp_len, .bus_err_irq);
    uep_host host_u (.pclk, .tok_valid, .tok_pid, .tok_len, .tok_crc_ok, .tok_overflow,
        .tok_underflow, .setup_data, .tx_done, .tx_acked);
    initial begin
        pclk = 1'h0;
        forever #12.5 pclk = ~pclk;
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic to_fail(input string n);
        bad_count++;
        $display("BAD %s exp done got timeout", n);
        print_verdict();
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'h1) break;
        end
        if (i == 20) to_fail("pready");
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask
    task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        chk(n, e, rd);
    endtask
    // Prime, wait for the request bit to drop, then judge the primed status
    task automatic prime(input logic [31:0] b, input logic [31:0] e);
        int i;
        wr(A_PRIME, b);
        for (i = 0; i < 20; i++) begin
            apb(1'h0, A_PRIME, 32'h0);
            if ((rd & b) === 32'h0) break;
        end
        if (i == 20) to_fail("prime");
        apb(1'h0, A_STATUS, 32'h0);
        chk("primed", e, rd & b);
    endtask
    task automatic tk(input uep_tok_t p, input logic [10:0] n, input logic [2:0] f,
        input logic v, input uep_rsp_t c);
        host_u.tok(p, n, f, sdat);
        #1;
        chk("resp", 32'({v, c}), 32'({resp_valid, resp_code}));
    endtask
    task automatic pkt_in(input logic [10:0] n, input logic a);
        tk(TOK_IN, 11'h000, 3'h4, 1'h1, RSP_DATA);
        chk("len", 32'(n), 32'(resp_len));
        host_u.txd(a);
    endtask
    task automatic t_reset();
        rc("rx_td", A_RX_TD, 32'h0001_0000);
        rc("tx_nx", A_TX_NX, 32'h0001_0000);
        apb(1'h0, 8'h3C, 32'h0);
        chk("slverr", 32'h1, 32'(er));
        tk(TOK_IN, 11'h000, 3'h4, 1'h1, RSP_NAK);
        $display("test reset done");
    endtask
    task automatic t_bulk();
        wr(A_EPCTRL, 32'h0000_000B);
        tk(TOK_IN, 11'h000, 3'h4, 1'h1, RSP_STALL);
        tk(TOK_OUT, 11'h010, 3'h4, 1'h1, RSP_STALL);
        tk(TOK_PING, 11'h000, 3'h4, 1'h1, RSP_STALL);
        tk(TOK_SETUP, 11'h000, 3'h4, 1'h0, RSP_NONE);
        tk(TOK_BAD, 11'h000, 3'h4, 1'h0, RSP_NONE);
        wr(A_EPCTRL, 32'h0000_0008);
        tk(TOK_IN, 11'h000, 3'h4, 1'h1, RSP_NAK);
        tk(TOK_OUT, 11'h010, 3'h4, 1'h1, RSP_NAK);
        tk(TOK_PING, 11'h000, 3'h4, 1'h1, RSP_NAK);
        wr(A_TX_QH, 32'h0000_0100);
        wr(A_TX_TD, 32'h8001_0200);
        prime(32'h2, 32'h2);
        pkt_in(11'h100, 1'h0);
        pkt_in(11'h100, 1'h1);
        pkt_in(11'h100, 1'h1);
        pkt_in(11'h000, 1'h1);
        rc("tx_td", A_TX_TD, 32'h0001_0000);
        rc("status", A_STATUS, 32'h0);
        $display("test bulk in done");
    endtask
    task automatic t_rx();
        wr(A_RX_QH, 32'h0000_8100);
        wr(A_RX_TD, 32'h8001_0200);
        prime(32'h1, 32'h1);
        tk(TOK_PING, 11'h000, 3'h4, 1'h1, RSP_ACK);
        tk(TOK_OUT, 11'h100, 3'h6, 1'h1, RSP_NAK);
        tk(TOK_OUT, 11'h100, 3'h0, 1'h0, RSP_NONE);
        tk(TOK_OUT, 11'h100, 3'h4, 1'h1, RSP_ACK);
        tk(TOK_OUT, 11'h100, 3'h4, 1'h1, RSP_NYET);
        rc("rx_td", A_RX_TD, 32'h0001_0000);
        wr(A_RX_TD, 32'h8001_0200);
        prime(32'h1, 32'h1);
        tk(TOK_OUT, 11'h064, 3'h4, 1'h1, RSP_NYET);
        rc("rx_td", A_RX_TD, 32'h0001_019C);
        wr(A_RX_TD, 32'h8001_0200);
        prime(32'h1, 32'h1);
        tk(TOK_OUT, 11'h12C, 3'h4, 1'h0, RSP_NONE);
        apb(1'h0, A_RX_TD, 32'h0);
        chk("berr", 32'h4000_0000, rd & 32'h4000_0000);
        rc("status", A_STATUS, 32'h0);
        chk("irq", 32'h1, 32'(bus_err_irq));
        wr(A_ERR, 32'h1);
        rc("err", A_ERR, 32'h0);
        $display("test bulk out done");
    endtask
    task automatic t_ctrl();
        wr(A_EPCTRL, 32'h0);
        wr(A_MODE, 32'h1);
        wr(A_RX_QH, 32'h0);
        wr(A_RX_TD, 32'h8001_0040);
        prime(32'h1, 32'h0);
        wr(A_RX_QH, 32'h0000_0040);
        prime(32'h1, 32'h1);
        wr(A_TX_TD, 32'h8001_0010);
        prime(32'h2, 32'h2);
        tk(TOK_IN, 11'h000, 3'h5, 1'h1, RSP_BSERR);
        wr(A_EPCTRL, 32'h3);
        wr(A_CMD, 32'h1);
        sdat = 64'h1122_3344_5566_7788;
        tk(TOK_SETUP, 11'h000, 3'h4, 1'h1, RSP_ACK);
        rc("stall", A_EPCTRL, 32'h0);
        rc("sstat", A_SETUP_STAT, 32'h1);
        rc("trip", A_CMD, 32'h0);
        rc("status", A_STATUS, 32'h0);
        rc("setup0", A_SETUP0, 32'h5566_7788);
        rc("setup1", A_SETUP1, 32'h1122_3344);
        wr(A_MODE, 32'h0);
        tk(TOK_SETUP, 11'h000, 3'h4, 1'h0, RSP_NONE);
        wr(A_SETUP_STAT, 32'h1);
        rc("sstat", A_SETUP_STAT, 32'h0);
        tk(TOK_SETUP, 11'h000, 3'h4, 1'h1, RSP_ACK);
        wr(A_SETUP_STAT, 32'h1);
        wr(A_TX_QH, 32'h0000_8010);
        wr(A_TX_TD, 32'h8000_0000);
        wr(A_TX_NX, 32'h8001_0010);
        prime(32'h2, 32'h2);
        rc("sstat", A_SETUP_STAT, 32'h0);
        pkt_in(11'h000, 1'h1);
        rc("tx_td", A_TX_TD, 32'h8001_0010);
        pkt_in(11'h010, 1'h1);
        rc("status", A_STATUS, 32'h0);
        $display("test control done");
    endtask
    initial begin
        presetn = 1'h0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        sdat = 64'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'h1;
        t_reset();
        t_bulk();
        t_rx();
        t_ctrl();
        print_verdict();
    end
endmodule
